/* File: hw/sarseq_approx.sv */
// successive approximation value with its one-hot trial bit
// assumes the sequencer pulses load once per conversion, then decide once per bit
module sarseq_approx #(
	parameter int BITS = 10
) (
	input  wire logic            clk_in,
	input  wire logic            rst_b_in,
	input  wire logic            load_in,
	input  wire logic            decide_in,
	input  wire logic            comp_in,
	output logic [BITS-1:0]      value_out,
	output logic                 last_out
);
	logic [BITS-1:0] probe;
	localparam logic [BITS-1:0] TOP = {1'b1, {(BITS-1){1'b0}}};
	// first step asks for the half-reference tap
	always_ff @(posedge clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			value_out <= '0;
			probe     <= '0;
		end
		else if (load_in)
		begin
			value_out <= TOP;
			probe     <= TOP;
		end
		else if (decide_in)
		begin
			// keep the trial bit on input >= tap, then try the next lower bit
			if (probe[0])
				value_out <= comp_in ? value_out : value_out & ~probe;
			else
				value_out <= (comp_in ? value_out : value_out & ~probe) | (probe >> 1);
			if (!probe[0])
				probe <= probe >> 1;
		end
	assign last_out = probe[0];
endmodule // sarseq_approx

/* File: hw/sarseq_pkg.sv */
// constants and carrier types of the sar converter sequencer
// assumes one 10 MHz peripheral clock for all users
package sarseq_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int SETTLE_NS     = 1000;
	localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RES_BITS      = 10;
	localparam int RESULT_W      = 16;
	localparam int PINS          = 8;
	// ******************************
	// register byte addresses
	// ******************************
	localparam logic [15:0] A_LATCH  = 16'hff02;
	localparam logic [15:0] A_RES_LO = 16'hff08;
	localparam logic [15:0] A_RES_HI = 16'hff09;
	localparam logic [15:0] A_RES_B  = 16'hff0a;
	localparam logic [15:0] A_DIR    = 16'hff22;
	localparam logic [15:0] A_CTRL   = 16'hff28;
	localparam logic [15:0] A_CHAN   = 16'hff29;
	localparam logic [15:0] A_STAT   = 16'hff2a;
	localparam logic [15:0] A_CFG    = 16'hff2f;
	// ******************************
	// reset values and fields
	// ******************************
	localparam logic [7:0]  DIR_RST   = 8'hff;
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [7:0]  LATCH_RST = 8'h00;
	localparam logic [2:0]  CHAN_RST  = 3'h0;
	localparam logic [3:0]  CFG_RST   = 4'h0;
	localparam logic [15:0] WORD_RST  = 16'h0000;
	localparam logic [7:0]  BYTE_RST  = 8'h00;
	localparam logic [3:0]  CFG_ALL_D = 4'h8;
	localparam logic [7:0]  CTRL_MASK = 8'hbf;
	localparam int B_ENABLE = 0;
	localparam int B_LV_LO  = 1;
	localparam int B_LV_HI  = 2;
	localparam int B_FR_LSB = 3;
	localparam int B_FR_MSB = 5;
	localparam int B_START  = 7;
	localparam int S_BUSY   = 0;
	localparam int S_SAMP   = 1;
	localparam int S_BAD    = 2;
	localparam int S_READY  = 3;
	localparam logic [7:0] SAMPLE_BASE = 8'h04;
	// cycles per comparison step, indexed by the clock ratio field
	function automatic logic [7:0] step_cyc(input logic [2:0] fr);
		case (fr)
			3'h0:    step_cyc = 8'h02;
			3'h1:    step_cyc = 8'h03;
			3'h2:    step_cyc = 8'h04;
			3'h3:    step_cyc = 8'h06;
			3'h4:    step_cyc = 8'h08;
			3'h5:    step_cyc = 8'h0c;
			3'h6:    step_cyc = 8'h10;
			default: step_cyc = 8'h18;
		endcase
	endfunction
	// longer sampling for the lower reference ranges
	function automatic logic [7:0] samp_cyc(input logic [1:0] lv);
		samp_cyc = SAMPLE_BASE * ({6'h00, lv} + 8'h01);
	endfunction
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} sarseq_bus_t;
	typedef enum {ST_IDLE, ST_SAMPLE, ST_COMPARE} sarseq_state_t;
endpackage

/* File: hw/sarseq_top.sv */
// sar converter sequencer: registers, pin function decode, sample and convert control
// assumes a synchronous cpu strobe bus and an external comparator with tap network
module sarseq_top #(
	parameter int RES_BITS = sarseq_pkg::RES_BITS
) (
	input  wire logic                  clk_in,
	input  wire logic                  rst_b_in,
	input  wire sarseq_pkg::sarseq_bus_t bus_in,
	output logic [7:0]                 rdata_out,
	input  wire logic [7:0]            shared_port_pins_in,
	output logic [7:0]                 shared_port_pins_out,
	output logic [7:0]                 shared_port_pins_oe_b_out,
	input  wire logic                  comparator_in,
	output logic                       comparator_enable_out,
	output logic [2:0]                 channel_code_out,
	output logic [7:0]                 analog_inputs_out,
	output logic [7:0]                 convert_select_out,
	output logic                       sample_out,
	output logic                       hold_out,
	output logic [RES_BITS-1:0]        tap_code_out,
	output logic                       conversion_done_irq_out
);
	localparam int ZB = sarseq_pkg::RESULT_W - RES_BITS;
	localparam logic [RES_BITS-1:0] TAP_HALF = {1'b1, {(RES_BITS-1){1'b0}}};

	// the result word and byte layouts need 8..15 bits of resolution
	if (RES_BITS < 8 || RES_BITS > 15)
	begin : g_bad_res
		$error("sarseq_top: RES_BITS must be 8 to 15");
	end

	// ****************************************
	// reset release
	// ****************************************
	logic rst_meta_b;
	logic rst_b;
	always_ff @(posedge clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			rst_meta_b <= 1'b0;
			rst_b      <= 1'b0;
		end
		else
		begin
			rst_meta_b <= 1'b1;
			rst_b      <= rst_meta_b;
		end

	// ****************************************
	// register file
	// ****************************************
	logic [7:0]                dir;
	logic [7:0]                latch;
	logic [7:0]                ctrl;
	logic [2:0]                chan;
	logic [3:0]                cfg;
	logic [15:0]               res_word;
	logic [7:0]                res_byte;
	logic [7:0]                next_ctrl;
	logic                      next_start;
	logic                      wr_dir;
	logic                      wr_latch;
	logic                      wr_ctrl;
	logic                      wr_chan;
	logic                      wr_cfg;
	sarseq_pkg::sarseq_state_t state;
	sarseq_pkg::sarseq_state_t next_state;
	logic [7:0]                cnt;
	logic [7:0]                run_step;
	logic [7:0]                run_samp;
	logic [7:0]                settle;
	logic [7:0]                analog;
	logic [7:0]                port_rd;
	logic                      bad_cfg;
	logic [RES_BITS-1:0]       fin;
	logic                      last;
	logic                      load_samp;
	logic                      enter_cmp;
	logic                      decide;
	logic                      commit;

	assign wr_dir   = bus_in.wr && (bus_in.addr == sarseq_pkg::A_DIR);
	assign wr_latch = bus_in.wr && (bus_in.addr == sarseq_pkg::A_LATCH);
	assign wr_ctrl  = bus_in.wr && (bus_in.addr == sarseq_pkg::A_CTRL);
	assign wr_chan  = bus_in.wr && (bus_in.addr == sarseq_pkg::A_CHAN);
	assign wr_cfg   = bus_in.wr && (bus_in.addr == sarseq_pkg::A_CFG);
	// a control write acts in its own cycle, so a stop never lets one more step run
	assign next_ctrl  = wr_ctrl ? (bus_in.wdata & sarseq_pkg::CTRL_MASK) : ctrl;
	assign next_start = next_ctrl[sarseq_pkg::B_START];

	// port direction and output latch
	always_ff @(posedge clk_in or negedge rst_b)
		if (!rst_b)
		begin
			dir   <= sarseq_pkg::DIR_RST;
			latch <= sarseq_pkg::LATCH_RST;
		end
		else
		begin
			if (wr_dir)
				dir <= bus_in.wdata;
			if (wr_latch)
				latch <= bus_in.wdata;
		end

	// converter control, channel code and pin configuration
	always_ff @(posedge clk_in or negedge rst_b)
		if (!rst_b)
		begin
			ctrl <= sarseq_pkg::CTRL_RST;
			chan <= sarseq_pkg::CHAN_RST;
			cfg  <= sarseq_pkg::CFG_RST;
		end
		else
		begin
			ctrl <= next_ctrl;
			if (wr_chan)
				chan <= bus_in.wdata[2:0];
			if (wr_cfg)
				cfg <= bus_in.wdata[3:0];
		end

	// comparator settling count, shown in status; starting early is allowed but unsettled
	always_ff @(posedge clk_in or negedge rst_b)
		if (!rst_b)
			settle <= 8'h00;
		else if (!ctrl[sarseq_pkg::B_ENABLE])
			settle <= 8'h00;
		else if (settle != 8'(sarseq_pkg::SETTLE_CYC))
			settle <= settle + 8'h01;

	// ****************************************
	// pin function decode
	// ****************************************
	for (genvar i = 0; i < sarseq_pkg::PINS; i++)
	begin : g_pin
		// pins at and above the config code are analog; codes above 8 fall back to digital
		assign analog[i] = (cfg <= sarseq_pkg::CFG_ALL_D) && (4'(i) >= cfg);
		assign port_rd[i] = analog[i] ? 1'b0 :
			(dir[i] ? shared_port_pins_in[i] : latch[i]);
		always_ff @(posedge clk_in or negedge rst_b)
			if (!rst_b)
			begin
				shared_port_pins_oe_b_out[i] <= 1'b1;
				shared_port_pins_out[i]      <= 1'b0;
				analog_inputs_out[i]         <= 1'b0;
				convert_select_out[i]        <= 1'b0;
			end
			else
			begin
				// analog pins keep the buffer off, so the latch cannot disturb them
				shared_port_pins_oe_b_out[i] <= dir[i] | analog[i];
				shared_port_pins_out[i]      <= latch[i];
				analog_inputs_out[i]         <= analog[i] & dir[i];
				convert_select_out[i]        <= analog[i] & dir[i] & (chan == 3'(i));
			end
	end
	// analog pin left in output mode is the prohibited case
	assign bad_cfg = |(analog & ~dir);

	// ****************************************
	// conversion sequencer
	// ****************************************
	always_comb
	begin
		next_state = state;
		if (!next_start)
			next_state = sarseq_pkg::ST_IDLE;
		else if (wr_chan)
			next_state = sarseq_pkg::ST_SAMPLE;
		else
			case (state)
				sarseq_pkg::ST_IDLE:
					next_state = sarseq_pkg::ST_SAMPLE;
				sarseq_pkg::ST_SAMPLE:
					if (cnt == 8'h00)
						next_state = sarseq_pkg::ST_COMPARE;
				sarseq_pkg::ST_COMPARE:
					if (cnt == 8'h00 && last)
						next_state = sarseq_pkg::ST_SAMPLE;
				default:
					next_state = sarseq_pkg::ST_IDLE;
			endcase
	end

	assign load_samp = (next_state == sarseq_pkg::ST_SAMPLE) &&
		(state != sarseq_pkg::ST_SAMPLE || wr_chan);
	assign enter_cmp = (state == sarseq_pkg::ST_SAMPLE) &&
		(next_state == sarseq_pkg::ST_COMPARE);
	assign decide = (state == sarseq_pkg::ST_COMPARE) && (cnt == 8'h00) &&
		next_start && !wr_chan;
	// a control or config write at the last step wins: no result, no pulse
	assign commit = decide && last && !wr_ctrl && !wr_cfg;
	assign fin = comparator_in ? tap_code_out : (tap_code_out & ~RES_BITS'(1));

	always_ff @(posedge clk_in or negedge rst_b)
		if (!rst_b)
			state <= sarseq_pkg::ST_IDLE;
		else
			state <= next_state;

	// step lengths are frozen per conversion so the timing stays exact
	always_ff @(posedge clk_in or negedge rst_b)
		if (!rst_b)
		begin
			cnt      <= 8'h00;
			run_step <= 8'h01;
			run_samp <= 8'h01;
		end
		else if (load_samp)
		begin
			run_samp <= sarseq_pkg::samp_cyc(next_ctrl[sarseq_pkg::B_LV_HI:sarseq_pkg::B_LV_LO]);
			run_step <= sarseq_pkg::step_cyc(next_ctrl[sarseq_pkg::B_FR_MSB:sarseq_pkg::B_FR_LSB]);
			cnt      <= sarseq_pkg::samp_cyc(next_ctrl[sarseq_pkg::B_LV_HI:sarseq_pkg::B_LV_LO])
				- 8'h01;
		end
		else if (enter_cmp || (decide && !last))
			cnt <= run_step - 8'h01;
		else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;

	sarseq_approx #(
		.BITS (RES_BITS)
	) u_approx (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b),
		.load_in   (enter_cmp),
		.decide_in (decide),
		.comp_in   (comparator_in),
		.value_out (tap_code_out),
		.last_out  (last)
	);

	// results and done pulse move together
	always_ff @(posedge clk_in or negedge rst_b)
		if (!rst_b)
		begin
			res_word                <= sarseq_pkg::WORD_RST;
			res_byte                <= sarseq_pkg::BYTE_RST;
			conversion_done_irq_out <= 1'b0;
		end
		else
		begin
			conversion_done_irq_out <= commit;
			if (commit)
			begin
				res_word <= {fin, {ZB{1'b0}}};
				res_byte <= fin[RES_BITS-1 -: 8];
			end
		end

	// analog side controls
	always_ff @(posedge clk_in or negedge rst_b)
		if (!rst_b)
		begin
			comparator_enable_out <= 1'b0;
			channel_code_out      <= sarseq_pkg::CHAN_RST;
			sample_out            <= 1'b0;
			hold_out              <= 1'b0;
		end
		else
		begin
			comparator_enable_out <= next_ctrl[sarseq_pkg::B_ENABLE];
			channel_code_out      <= wr_chan ? bus_in.wdata[2:0] : chan;
			sample_out            <= next_state == sarseq_pkg::ST_SAMPLE;
			hold_out              <= next_state == sarseq_pkg::ST_COMPARE;
		end

	// ****************************************
	// read port
	// ****************************************
	always_ff @(posedge clk_in or negedge rst_b)
		if (!rst_b)
			rdata_out <= 8'h00;
		else if (!bus_in.rd)
			rdata_out <= 8'h00;
		else if (bus_in.addr == sarseq_pkg::A_DIR)
			rdata_out <= dir;
		else if (bus_in.addr == sarseq_pkg::A_LATCH)
			rdata_out <= port_rd;
		else if (bus_in.addr == sarseq_pkg::A_CTRL)
			rdata_out <= ctrl;
		else if (bus_in.addr == sarseq_pkg::A_CHAN)
			rdata_out <= {5'h00, chan};
		else if (bus_in.addr == sarseq_pkg::A_CFG)
			rdata_out <= {4'h0, cfg};
		else if (bus_in.addr == sarseq_pkg::A_RES_LO)
			rdata_out <= res_word[7:0];
		else if (bus_in.addr == sarseq_pkg::A_RES_HI)
			rdata_out <= res_word[15:8];
		else if (bus_in.addr == sarseq_pkg::A_RES_B)
			rdata_out <= res_byte;
		else if (bus_in.addr == sarseq_pkg::A_STAT)
			rdata_out <= {4'h0,
				settle == 8'(sarseq_pkg::SETTLE_CYC),
				bad_cfg,
				state == sarseq_pkg::ST_SAMPLE,
				state != sarseq_pkg::ST_IDLE};
		else
			rdata_out <= 8'h00;

	// ****************************************
	// checks
	// ****************************************
	logic [15:0] since_load;
	logic [15:0] conv_exp;
	always_ff @(posedge clk_in or negedge rst_b)
		if (!rst_b)
		begin
			since_load <= 16'h0000;
			conv_exp   <= 16'h0000;
		end
		else
		begin
			since_load <= load_samp ? 16'h0000 : since_load + 16'h0001;
			conv_exp   <= {8'h00, run_samp} + 16'(RES_BITS) * {8'h00, run_step};
		end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b);

	sequence s_stop;
		wr_ctrl && !bus_in.wdata[sarseq_pkg::B_START] && state != sarseq_pkg::ST_IDLE;
	endsequence
	sequence s_rewrite;
		wr_chan && next_start;
	endsequence
	sequence s_first_step;
		decide && tap_code_out == TAP_HALF;
	endsequence

	a_dir_reset: assert property ($rose(rst_b) |-> dir == sarseq_pkg::DIR_RST &&
		res_word == sarseq_pkg::WORD_RST)
		else $error("reset values wrong");
	a_buffer_dir: assert property (1'b1 |=>
		shared_port_pins_oe_b_out == ($past(dir) | $past(analog)))
		else $error("buffer does not follow direction");
	a_analog_undriven: assert property ((analog_inputs_out & ~shared_port_pins_oe_b_out)
		== 8'h00)
		else $error("analog pin driven");
	a_first_tap: assert property (enter_cmp |=> tap_code_out == TAP_HALF && hold_out)
		else $error("first tap not half reference");
	a_msb_decide: assert property (s_first_step |=>
		tap_code_out[RES_BITS-1 -: 2] == {$past(comparator_in), 1'b1})
		else $error("msb decision or next trial wrong");
	a_result_form: assert property (res_word[ZB-1:0] == '0 &&
		res_word[15 -: 8] == res_byte)
		else $error("result layout wrong");
	a_irq_pulse: assert property (conversion_done_irq_out |=> !conversion_done_irq_out)
		else $error("done pulse too long");
	a_irq_result: assert property (commit |=> conversion_done_irq_out &&
		res_word[15 -: 8] == $past(fin[RES_BITS-1 -: 8]))
		else $error("result not latched with done");
	a_stop_now: assert property (s_stop |=> state == sarseq_pkg::ST_IDLE &&
		!conversion_done_irq_out && $stable(res_word))
		else $error("stop not immediate");
	a_chan_restart: assert property (s_rewrite |=> state == sarseq_pkg::ST_SAMPLE &&
		cnt == run_samp - 8'h01)
		else $error("channel write did not restart");
	a_conv_time: assert property (conversion_done_irq_out |->
		$past(since_load) == conv_exp - 16'h0001)
		else $error("conversion time wrong");
	a_repeat: assert property (conversion_done_irq_out |-> sample_out &&
		state == sarseq_pkg::ST_SAMPLE)
		else $error("no repeat after done");
endmodule // sarseq_top

/* File: tb/sar_adc_sequencer_tb_top.sv */
// self-checking bench for the sar converter sequencer
// assumes the strobe bus of the package and the comparator model beside the design
module sar_adc_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0][9:0] LEVELS = {10'h3fe, 10'h001, 10'h1ff, 10'h200,
		10'h155, 10'h2aa, 10'h000, 10'h3ff}; // channel 0 is the last entry
	localparam int STEP [8] = '{2, 3, 4, 6, 8, 12, 16, 24};
	logic                   clk_in = 1'b0;
	logic                   rst_b_in;
	sarseq_pkg::sarseq_bus_t bus;
	logic [7:0]             rdata, pins_out, oe_b, analog, csel;
	logic                   comp, cen, samp, hold, irq;
	logic [2:0]             chan;
	logic [9:0]             tap, tap0;
	int                     err_count = 0, n_tests = 0, cycles = 0;
	int                     n, ns, nh;

	always #50 clk_in = ~clk_in;

	sarseq_top uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus), .rdata_out(rdata),
		.shared_port_pins_in(8'h5a), .shared_port_pins_out(pins_out),
		.shared_port_pins_oe_b_out(oe_b), .comparator_in(comp),
		.comparator_enable_out(cen), .channel_code_out(chan), .analog_inputs_out(analog),
		.convert_select_out(csel), .sample_out(samp), .hold_out(hold), .tap_code_out(tap),
		.conversion_done_irq_out(irq));
	sarseq_comp_model u_comp (.clk_in(clk_in), .select_in(csel), .sample_in(samp),
		.hold_in(hold), .tap_in(tap), .level_in(LEVELS), .comp_out(comp));

	// ******************************
	// bus tasks and checks
	// ******************************
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
	endtask
	task automatic rd_chk(input string name, input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
		#1;
		check(name, {8'h00, rdata}, {8'h00, exp});
	endtask
	// counts edges up to the done pulse; n is -1 when none came
	task automatic wait_irq(input int limit);
		n = 0;
		ns = 0;
		nh = 0;
		while (n < limit)
		begin
			@(posedge clk_in);
			n++;
			#1;
			if (irq === 1'b1)
				return;
			if (hold === 1'b1 && nh == 0)
				tap0 = tap;
			ns += (samp === 1'b1);
			nh += (hold === 1'b1);
		end
		n = -1;
	endtask
	task automatic conv_chk(input logic [7:0] c, input int ch);
		int         s;
		logic [9:0] v;
		s = 4 * (int'(c[2:1]) + 1);
		v = LEVELS[ch];
		wait_irq(400);
		check("conv_time", 16'(n), 16'(s + 10 * STEP[c[5:3]]));
		// the start edge opens sampling before the first look, so one cycle goes unseen
		check("samp_time", 16'(ns), 16'(s - 1));
		check("hold_time", 16'(nh), 16'(10 * STEP[c[5:3]]));
		check("first_tap", {6'h00, tap0}, 16'h0200);
		@(posedge clk_in);
		#1;
		check("irq_pulse", {15'h0000, irq}, 16'h0000);
		rd_chk("word_hi", sarseq_pkg::A_RES_HI, v[9:2]);
		rd_chk("word_lo", sarseq_pkg::A_RES_LO, {v[1:0], 6'h00});
		rd_chk("res_byte", sarseq_pkg::A_RES_B, v[9:2]);
	endtask
	task automatic final_report();
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_count++;
			final_report();
		end
	end

	// ******************************
	// main sequence
	// ******************************
	initial
	begin
		bus = '{addr: 16'h0000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
		rst_b_in = 1'b0;
		repeat (3) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		rd_chk("dir_rst", sarseq_pkg::A_DIR, 8'hff);
		check("oe_rst", {8'h00, oe_b}, 16'h00ff);
		rd_chk("word_lo_rst", sarseq_pkg::A_RES_LO, 8'h00);
		rd_chk("word_hi_rst", sarseq_pkg::A_RES_HI, 8'h00);
		rd_chk("byte_rst", sarseq_pkg::A_RES_B, 8'h00);
		// all digital, high nibble driven, low nibble read back from the pins
		wr(sarseq_pkg::A_CFG, 8'h08);
		wr(sarseq_pkg::A_DIR, 8'h0f);
		wr(sarseq_pkg::A_LATCH, 8'h33);
		rd_chk("dir_rw", sarseq_pkg::A_DIR, 8'h0f);
		rd_chk("port_rd", sarseq_pkg::A_LATCH, 8'h3a);
		check("oe_dig", {8'h00, oe_b}, 16'h000f);
		check("pins_dig", {8'h00, pins_out}, 16'h0033);
		// all analog; an output-mode pin is neither an input nor converted
		wr(sarseq_pkg::A_CFG, 8'h00);
		wr(sarseq_pkg::A_CHAN, 8'h00);
		wr(sarseq_pkg::A_DIR, 8'hfe);
		repeat (2) @(posedge clk_in);
		#1;
		check("analog_bad", {8'h00, analog}, 16'h00fe);
		check("csel_bad", {8'h00, csel}, 16'h0000);
		rd_chk("stat_bad", sarseq_pkg::A_STAT, 8'h04);
		wr(sarseq_pkg::A_DIR, 8'hff);
		wr(sarseq_pkg::A_CHAN, 8'hff);
		rd_chk("chan_mask", sarseq_pkg::A_CHAN, 8'h07);
		wr(sarseq_pkg::A_CTRL, 8'h01);
		@(posedge clk_in);
		#1;
		check("comp_en", {15'h0000, cen}, 16'h0001);
		repeat (12) @(posedge clk_in);
		// every ratio and range, one channel each
		for (int r = 0; r < 8; r++)
		begin
			wr(sarseq_pkg::A_CHAN, 8'(r));
			@(posedge clk_in);
			#1;
			check("csel", {8'h00, csel}, {8'h00, 8'h01 << r});
			check("chan", {13'h0000, chan}, 16'(r));
			wr(sarseq_pkg::A_CTRL, 8'h81 | 8'(r << 3) | 8'((r % 4) << 1));
			conv_chk(8'h81 | 8'(r << 3) | 8'((r % 4) << 1), r);
			wr(sarseq_pkg::A_CTRL, 8'h01);
		end
		// latch flips on analog pins, then repeat, restart and stop
		wr(sarseq_pkg::A_LATCH, 8'hcc);
		wr(sarseq_pkg::A_CHAN, 8'h03);
		wr(sarseq_pkg::A_CTRL, 8'h81);
		wait_irq(400);
		wait_irq(400);
		check("repeat_time", 16'(n), 16'd24);
		check("repeat_samp", {15'h0000, samp}, 16'h0001);
		rd_chk("latch_free", sarseq_pkg::A_RES_HI, 8'(LEVELS[3] >> 2));
		check("oe_latch", {8'h00, oe_b}, 16'h00ff);
		repeat (10) @(posedge clk_in);
		wr(sarseq_pkg::A_CHAN, 8'h05);
		wait_irq(400);
		check("restart_time", 16'(n), 16'd24);
		rd_chk("restart_res", sarseq_pkg::A_RES_B, 8'(LEVELS[5] >> 2));
		repeat (10) @(posedge clk_in);
		wr(sarseq_pkg::A_CTRL, 8'h01);
		wait_irq(100);
		check("stop_irq", 16'(n), 16'hffff);
		check("stop_hold", {14'h0000, hold, samp}, 16'h0000);
		rd_chk("stop_keep", sarseq_pkg::A_RES_B, 8'(LEVELS[5] >> 2));
		// start with the comparator off: the first result is thrown away unread
		wr(sarseq_pkg::A_CTRL, 8'h00);
		wr(sarseq_pkg::A_CHAN, 8'h03);
		wr(sarseq_pkg::A_CTRL, 8'h80);
		wait_irq(400);
		wait_irq(400);
		check("noen_time", 16'(n), 16'd24);
		check("noen_cen", {15'h0000, cen}, 16'h0000);
		rd_chk("noen_res", sarseq_pkg::A_RES_B, 8'(LEVELS[3] >> 2));
		final_report();
	end
endmodule // sar_adc_sequencer_tb_top

/* File: tb/sarseq_comp_model.sv */
// behavioural comparator and resistor tap network on the converter's analog side
// assumes one-hot convert select plus sample and hold levels from the sequencer
module sarseq_comp_model (
	input  wire logic            clk_in,
	input  wire logic [7:0]      select_in,
	input  wire logic            sample_in,
	input  wire logic            hold_in,
	input  wire logic [9:0]      tap_in,
	input  wire logic [7:0][9:0] level_in,
	output logic                 comp_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] held;
	logic [9:0] pick;
	logic       junk = 1'b0;
	// one-hot select to level; nothing selected gives a moving code
	always_comb
	begin
		pick = {9'h000, junk};
		for (int i = 0; i < 8; i++)
			if (select_in[i])
				pick = level_in[i];
	end
	// track while sampling, keep the held level afterwards
	always_ff @(posedge clk_in)
	begin
		junk <= ~junk;
		if (sample_in)
			held <= pick;
	end
	// outside hold the answer is noise, so the sequencer must not use it
	assign comp_out = hold_in ? (held >= tap_in) : junk;
endmodule // sarseq_comp_model
